// file: hw/cls_link_port.sv
`timescale 1ns/1ps
module cls_link_port #(
    parameter int LANES = cls_pkg::LANES
) (
    input logic mclk,
    input logic rst_n,
    input logic core_reset,
    input logic cfg_mode64,
    input logic [cls_pkg::CFG_W-1:0] cfg_emb_len,
    input logic [cls_pkg::CFG_W-1:0] cfg_frm_len,
    input logic [cls_pkg::CFG_W-1:0] cfg_mf_frames,
    input logic xcvr_reset_done,
    output logic xcvr_reset_request,
    output logic stream_rst_n,
    input logic [LANES*cls_pkg::BLK_W-1:0] tx_tdata,
    output logic tx_tready,
    input logic [cls_pkg::CMD_W-1:0] tx_cmd_tdata,
    input logic tx_cmd_tvalid,
    output logic tx_cmd_tready,
    output logic tx_soemb,
    output logic [cls_pkg::MARK_W-1:0] tx_sof,
    output logic [cls_pkg::MARK_W-1:0] tx_somf,
    output logic [LANES*cls_pkg::BLK_W-1:0] tx_line_data,
    output logic [cls_pkg::CMD_W-1:0] tx_line_cmd,
    output logic tx_line_cmd_stb,
    input logic [LANES*cls_pkg::BLK_W-1:0] rx_line_data,
    input logic [cls_pkg::CMD_W-1:0] rx_line_cmd,
    output logic [LANES*cls_pkg::BLK_W-1:0] rx_tdata,
    output logic [cls_pkg::CMD_W-1:0] rx_cmd_tdata,
    output logic rx_cmd_tvalid,
    output logic rx_soemb,
    output logic [cls_pkg::MARK_W-1:0] rx_sof,
    output logic [cls_pkg::MARK_W-1:0] rx_somf
);
    import cls_pkg::*;

    localparam int DW = LANES * BLK_W;

    typedef struct packed {
        logic done_s1;
        logic done_s2;
        logic [3:0] req_cnt;
        logic xreq;
        logic srst_n;
        logic mode64;
        logic [CFG_W-1:0] emb_len;
        logic [POS_W-1:0] frm_len;
        logic [POS_W-1:0] mf_len;
        logic [4:0] blk;
        logic [CFG_W-1:0] mb;
        logic [POS_W-1:0] fpos;
        logic [POS_W-1:0] mpos;
        logic soemb;
        logic [MARK_W-1:0] sof;
        logic [MARK_W-1:0] somf;
        logic cmd_rdy;
        logic [DW-1:0] tx_data;
        logic [CMD_W-1:0] tx_cmd;
        logic tx_cmd_stb;
        logic [DW-1:0] rx_data;
        logic [CMD_W-1:0] rx_cmd;
        logic rx_cmd_v;
    } cls_port_t;

    cls_port_t q;
    cls_port_t d;
    cls_cfg_if cfg_bus ();
    logic hold;
    logic [MARK_W-1:0] sof_c;
    logic [MARK_W-1:0] somf_c;

    cls_cfg_hold u_cfg (
        .mclk(mclk),
        .rst_n(rst_n),
        .cfg_mode64(cfg_mode64),
        .cfg_emb_len(cfg_emb_len),
        .cfg_frm_len(cfg_frm_len),
        .cfg_mf_frames(cfg_mf_frames),
        .cfg(cfg_bus.src)
    );

    // byte position after one four-byte beat, wrapped to the length
    function automatic logic [POS_W-1:0] adv4(
        input logic [POS_W-1:0] p,
        input logic [POS_W-1:0] len
    );
        logic [POS_W-1:0] t;
        t = p + 16'h0004;
        for (int k = 0; k < 4; k++) begin
            if (len != 16'h0000 && t >= len) begin
                t = t - len;
            end
        end
        return (len == 16'h0000) ? 16'h0000 : t;
    endfunction : adv4

    // lengths below four bytes are covered up to three wraps a beat
    function automatic logic starts(
        input logic [POS_W-1:0] p,
        input logic [POS_W-1:0] len
    );
        return p == 16'h0000 || p == len || p == (len << 1) ||
            p == (len + (len << 1));
    endfunction : starts

    for (genvar i = 0; i < MARK_W; i++) begin : g_mark
        assign sof_c[i] = starts(q.fpos + POS_W'(i), q.frm_len);
        assign somf_c[i] = starts(q.mpos + POS_W'(i), q.mf_len);
    end

    assign hold = q.xreq || !q.done_s2;

    always_comb begin
        d = q;
        d.done_s1 = xcvr_reset_done;
        d.done_s2 = q.done_s1;
        if (q.req_cnt != 4'h0) begin
            d.req_cnt = q.req_cnt - 4'h1;
        end
        d.xreq = d.req_cnt != 4'h0;
        d.soemb = 1'b0;
        d.sof = '0;
        d.somf = '0;
        d.cmd_rdy = 1'b0;
        d.tx_cmd_stb = 1'b0;
        d.rx_cmd_v = 1'b0;
        d.tx_data = tx_tdata;
        d.rx_data = rx_line_data;
        if (q.srst_n) begin
            if (q.mode64) begin
                d.blk = q.blk + 5'h01;
                if (q.blk == BLK_LAST) begin
                    d.mb = (q.mb + 8'h01 >= q.emb_len) ? 8'h00
                        : q.mb + 8'h01;
                end
                d.soemb = q.blk == BLK_LAST && q.mb + 8'h01 >= q.emb_len;
                d.cmd_rdy = q.blk == BLK_PRE;
                if (q.cmd_rdy) begin
                    d.tx_cmd = tx_cmd_tvalid ? tx_cmd_tdata : CMD_IDLE;
                    d.tx_cmd_stb = 1'b1;
                end
                if (q.blk == BLK_LAST) begin
                    d.rx_cmd = rx_line_cmd;
                    d.rx_cmd_v = 1'b1;
                end
            end else begin
                d.sof = sof_c;
                d.somf = somf_c;
                d.fpos = adv4(q.fpos, q.frm_len);
                d.mpos = adv4(q.mpos, q.mf_len);
            end
        end
        d.srst_n = !hold;
        if (hold) begin
            d.mode64 = cfg_bus.mode64;
            d.emb_len = cfg_bus.emb_len;
            d.frm_len = {8'h00, cfg_bus.frm_len};
            d.mf_len = {8'h00, cfg_bus.frm_len} * {8'h00, cfg_bus.mf_frames};
            d.blk = 5'h00;
            d.mb = 8'h00;
            d.fpos = '0;
            d.mpos = '0;
            d.soemb = 1'b0;
            d.sof = '0;
            d.somf = '0;
            d.cmd_rdy = 1'b0;
            d.tx_cmd_stb = 1'b0;
            d.rx_cmd_v = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge core_reset) begin
        if (core_reset) begin
            q <= '{done_s1: 1'b0, done_s2: 1'b0, req_cnt: XREQ_CNT_RST,
                   xreq: 1'b1, srst_n: 1'b0, mode64: CFG_MODE64_RST,
                   emb_len: CFG_EMB_RST, frm_len: {8'h00, CFG_FRM_RST},
                   mf_len: {8'h00, CFG_FRM_RST} * {8'h00, CFG_MFF_RST},
                   blk: 5'h00, mb: 8'h00,
                   fpos: 16'h0000, mpos: 16'h0000, soemb: 1'b0,
                   sof: 4'h0, somf: 4'h0, cmd_rdy: 1'b0, tx_data: '0,
                   tx_cmd: CMD_IDLE, tx_cmd_stb: 1'b0, rx_data: '0,
                   rx_cmd: CMD_IDLE, rx_cmd_v: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign xcvr_reset_request = q.xreq;
    assign stream_rst_n = q.srst_n;
    assign tx_tready = q.srst_n;
    assign tx_cmd_tready = q.cmd_rdy;
    assign tx_soemb = q.soemb;
    assign rx_soemb = q.soemb;
    assign tx_sof = q.sof;
    assign rx_sof = q.sof;
    assign tx_somf = q.somf;
    assign rx_somf = q.somf;
    assign tx_line_data = q.tx_data;
    assign tx_line_cmd = q.tx_cmd;
    assign tx_line_cmd_stb = q.tx_cmd_stb;
    assign rx_tdata = q.rx_data;
    assign rx_cmd_tdata = q.rx_cmd;
    assign rx_cmd_tvalid = q.rx_cmd_v;

    a_xreq_after_reset: assert property (@(posedge mclk)
        disable iff (core_reset)
        $past(q.req_cnt) == XREQ_CNT_RST |-> q.xreq && !q.srst_n)
        else $error("request or stream reset wrong after core reset");

    a_xreq_length: assert property (@(posedge mclk)
        disable iff (core_reset)
        $fell(q.xreq) |-> $past(q.xreq, 7))
        else $error("transceiver request too short");

    a_done_holds: assert property (@(posedge mclk)
        disable iff (core_reset)
        !q.done_s2 |=> !q.srst_n)
        else $error("stream released while reset-done low");

    a_srst_release: assert property (@(posedge mclk)
        disable iff (core_reset)
        $rose(q.srst_n) |-> $past(q.done_s2) && !$past(q.xreq))
        else $error("stream reset released without done");

    a_beat_passes: assert property (@(posedge mclk)
        disable iff (core_reset)
        q.srst_n |=> tx_line_data == $past(tx_tdata) && tx_tready)
        else $error("data beat lost or stalled");

    a_soemb_align: assert property (@(posedge mclk)
        disable iff (core_reset)
        tx_soemb |-> $past(tx_cmd_tready) ##1 (!tx_soemb)[*8])
        else $error("extended multiblock marker misplaced");

    a_cmd_once: assert property (@(posedge mclk)
        disable iff (core_reset)
        tx_cmd_tready |=> (!tx_cmd_tready)[*8])
        else $error("command taken twice in a multiblock");

    a_cmd_idle: assert property (@(posedge mclk)
        disable iff (core_reset)
        tx_cmd_tready && !tx_cmd_tvalid |=>
            tx_line_cmd_stb && tx_line_cmd == CMD_IDLE)
        else $error("idle command not inserted");

    a_rx_cmd_pace: assert property (@(posedge mclk)
        disable iff (core_reset)
        rx_cmd_tvalid |-> $past(tx_cmd_tready) && $past(q.blk) == BLK_LAST)
        else $error("received command off multiblock end");

    a_sof_first: assert property (@(posedge mclk)
        disable iff (core_reset)
        tx_sof[0] |-> $past(q.fpos) == 16'h0000 && !$past(q.mode64))
        else $error("frame start marker without frame start");

    a_cfg_frozen: assert property (@(posedge mclk)
        disable iff (core_reset)
        q.srst_n && $past(q.srst_n) |-> $stable(q.frm_len) &&
            $stable(q.emb_len) && $stable(q.mode64))
        else $error("settings changed while link running");

    a_rx_beat_passes: assert property (@(posedge mclk)
        disable iff (core_reset)
        q.srst_n |=> rx_tdata == $past(rx_line_data))
        else $error("received beat lost or stalled");

    a_somf_first: assert property (@(posedge mclk)
        disable iff (core_reset)
        tx_somf[0] |-> $past(q.mpos) == 16'h0000 && !$past(q.mode64))
        else $error("multiframe marker without multiframe start");

    a_marks_quiet: assert property (@(posedge mclk)
        disable iff (core_reset)
        q.mode64 |-> tx_sof == 4'h0 && tx_somf == 4'h0)
        else $error("frame markers raised in 64b66b mode");

    a_cmd_pair: assert property (@(posedge mclk)
        disable iff (core_reset)
        tx_line_cmd_stb |-> rx_cmd_tvalid)
        else $error("command strobes out of step");
endmodule : cls_link_port

// file: hw/cls_pkg.sv
package cls_pkg;
    localparam int BLK_W = 64;
    localparam int LANE32_W = 32;
    localparam int CMD_W = 19;
    localparam int MARK_W = 4;
    localparam int CFG_W = 8;
    localparam int POS_W = 16;
    localparam int LANES = 4;
    // last block index of a 32-block multiblock
    localparam logic [4:0] BLK_LAST = 5'h1f;
    localparam logic [4:0] BLK_PRE = 5'h1e;
    localparam logic [18:0] CMD_IDLE = 19'h00000;
    localparam int MCLK_NS = 25;
    localparam int XREQ_NS = 200;
    localparam int XREQ_CYC = (XREQ_NS + MCLK_NS - 1) / MCLK_NS;
    localparam logic [3:0] XREQ_CNT_RST = 4'(XREQ_CYC);
    localparam logic CFG_MODE64_RST = 1'b1;
    localparam logic [7:0] CFG_EMB_RST = 8'h01;
    localparam logic [7:0] CFG_FRM_RST = 8'h08;
    localparam logic [7:0] CFG_MFF_RST = 8'h04;
endpackage : cls_pkg

// file: hw/cls_cfg_if.sv
`timescale 1ns/1ps
interface cls_cfg_if;
    logic mode64;
    logic [7:0] emb_len;
    logic [7:0] frm_len;
    logic [7:0] mf_frames;
    modport src (output mode64, output emb_len, output frm_len,
                 output mf_frames);
    modport dst (input mode64, input emb_len, input frm_len,
                 input mf_frames);
endinterface : cls_cfg_if

// file: hw/cls_cfg_hold.sv
`timescale 1ns/1ps
module cls_cfg_hold (
    input logic mclk,
    input logic rst_n,
    input logic cfg_mode64,
    input logic [cls_pkg::CFG_W-1:0] cfg_emb_len,
    input logic [cls_pkg::CFG_W-1:0] cfg_frm_len,
    input logic [cls_pkg::CFG_W-1:0] cfg_mf_frames,
    cls_cfg_if.src cfg
);
    import cls_pkg::*;

    typedef struct packed {
        logic [24:0] s1;
        logic [24:0] s2;
        logic [24:0] s3;
        logic [24:0] held;
    } cls_cfgh_t;

    localparam logic [24:0] HELD_RST =
        {CFG_MODE64_RST, CFG_EMB_RST, CFG_FRM_RST, CFG_MFF_RST};

    cls_cfgh_t q;
    cls_cfgh_t d;

    always_comb begin
        d = q;
        d.s1 = {cfg_mode64, cfg_emb_len, cfg_frm_len, cfg_mf_frames};
        d.s2 = q.s1;
        d.s3 = q.s2;
        // a word is taken only once it has stood still two cycles
        if (q.s2 == q.s3) begin
            d.held = q.s3;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{s1: HELD_RST, s2: HELD_RST, s3: HELD_RST,
                   held: HELD_RST};
        end else begin
            q <= d;
        end
    end

    assign cfg.mode64 = q.held[24];
    assign cfg.emb_len = q.held[23:16];
    assign cfg.frm_len = q.held[15:8];
    assign cfg.mf_frames = q.held[7:0];

    a_cfg_settle: assert property (@(posedge mclk)
        disable iff (!rst_n)
        q.held != $past(q.held) |-> $past(q.s2) == $past(q.s3))
        else $error("config word taken while still moving");
endmodule : cls_cfg_hold

// file: bench/cls_app_model.sv
`timescale 1ns/1ps
module cls_app_model (
    input logic mclk,
    input logic tx_tready,
    input logic tx_cmd_tready,
    output logic [cls_pkg::LANES*cls_pkg::BLK_W-1:0] tx_tdata,
    output logic [cls_pkg::CMD_W-1:0] tx_cmd_tdata,
    output logic tx_cmd_tvalid
);
    import cls_pkg::*;
    integer seed = 32'hbcf2fc3a;
    logic took = 1'b0;
    initial begin
        tx_tdata = '0;
        tx_cmd_tdata = '0;
        tx_cmd_tvalid = 1'b0;
    end
    // command must stay put until the edge that takes it
    always @(posedge mclk) took <= tx_cmd_tready;
    always @(negedge mclk) begin
        // fresh block every cycle
        // nothing is taken in reset, so no block is drawn then
        if (tx_tready) begin
            for (int i = 0; i < LANES * BLK_W / 32; i++) begin
                tx_tdata[i*32 +: 32] <= $random(seed);
            end
        end
        if (took) begin
            tx_cmd_tdata <= 19'($random(seed));
            tx_cmd_tvalid <= 1'($random(seed));
        end
    end
endmodule : cls_app_model

// file: bench/test_converter_link_stream_port.sv
`timescale 1ns/1ps
module test_converter_link_stream_port;
    import cls_pkg::*;
    localparam int DW = LANES * BLK_W;
    localparam int EMB = 2;
    localparam int FRM = 4;
    localparam int MFF = 3;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic core_reset = 1'b1;
    logic cfg_mode64 = 1'b1;
    logic [CFG_W-1:0] cfg_emb_len = 8'h02;
    logic [CFG_W-1:0] cfg_frm_len = 8'h04;
    logic [CFG_W-1:0] cfg_mf_frames = 8'h03;
    logic xcvr_reset_done = 1'b0;
    logic xcvr_reset_request, stream_rst_n, tx_tready, tx_cmd_tready;
    logic [DW-1:0] tx_tdata, tx_line_data, rx_tdata;
    logic [DW-1:0] rx_line_data = '0;
    logic [CMD_W-1:0] tx_cmd_tdata, tx_line_cmd, rx_cmd_tdata;
    logic [CMD_W-1:0] rx_line_cmd = '0;
    logic tx_cmd_tvalid, tx_line_cmd_stb, rx_cmd_tvalid;
    logic tx_soemb, rx_soemb;
    logic [MARK_W-1:0] tx_sof, tx_somf, rx_sof, rx_somf;
    integer seed = 32'hbcf2fc3a;
    int num_errors = 0;
    int tests_run = 0;
    logic chk_on = 1'b0;
    logic m64 = 1'b1;
    logic pend = 1'b0;
    logic pv;
    logic [CMD_W-1:0] pc, prc;
    logic [DW-1:0] prx;
    logic [DW-1:0] q[$];
    int cnt = 0;

    logic xcvr_power_ok = 1'b0;

    // 25 ns core clock stands for line rate over 66
    // shared clock buffer runs only once power is ok
    // ideal clock, no pll phase to sample against
    always #12.5 mclk = xcvr_power_ok ? ~mclk : 1'b0;

    initial #40 xcvr_power_ok = 1'b1;

    cls_link_port #(.LANES(LANES)) u_dut (.mclk(mclk), .rst_n(rst_n),
        .core_reset(core_reset), .cfg_mode64(cfg_mode64),
        .cfg_emb_len(cfg_emb_len), .cfg_frm_len(cfg_frm_len),
        .cfg_mf_frames(cfg_mf_frames), .xcvr_reset_done(xcvr_reset_done),
        .xcvr_reset_request(xcvr_reset_request),
        .stream_rst_n(stream_rst_n), .tx_tdata(tx_tdata),
        .tx_tready(tx_tready), .tx_cmd_tdata(tx_cmd_tdata),
        .tx_cmd_tvalid(tx_cmd_tvalid), .tx_cmd_tready(tx_cmd_tready),
        .tx_soemb(tx_soemb), .tx_sof(tx_sof), .tx_somf(tx_somf),
        .tx_line_data(tx_line_data), .tx_line_cmd(tx_line_cmd),
        .tx_line_cmd_stb(tx_line_cmd_stb), .rx_line_data(rx_line_data),
        .rx_line_cmd(rx_line_cmd), .rx_tdata(rx_tdata),
        .rx_cmd_tdata(rx_cmd_tdata), .rx_cmd_tvalid(rx_cmd_tvalid),
        .rx_soemb(rx_soemb), .rx_sof(rx_sof), .rx_somf(rx_somf));

    cls_app_model u_app (.mclk(mclk), .tx_tready(tx_tready),
        .tx_cmd_tready(tx_cmd_tready), .tx_tdata(tx_tdata),
        .tx_cmd_tdata(tx_cmd_tdata), .tx_cmd_tvalid(tx_cmd_tvalid));

    task automatic chk(input string name, input logic [DW-1:0] seen,
                       input logic [DW-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic stop_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    function automatic logic [3:0] mark(input int n, input int len);
        logic [3:0] m;
        for (int i = 0; i < 4; i++) begin
            m[i] = ((4 * n + i) % len) == 0;
        end
        return m;
    endfunction : mark

    task automatic check_beat();
        logic last;
        logic emb;
        chk("tx_line_data", tx_line_data, q.pop_front());
        chk("rx_tdata", rx_tdata, prx);
        if (m64) begin
            last = (cnt % 32) == 31;
            emb = last && ((cnt / 32) % EMB) == EMB - 1;
            chk("stb", {tx_line_cmd_stb, rx_cmd_tvalid}, {2{last}});
            chk("sof_off", {tx_sof, tx_somf, rx_sof, rx_somf}, 16'h0);
            chk("soemb", {tx_soemb, rx_soemb}, {emb, emb});
            if (last) begin
                chk("tx_line_cmd", tx_line_cmd, pv ? pc : CMD_IDLE);
                chk("rx_cmd_tdata", rx_cmd_tdata, prc);
            end
        end else begin
            chk("sof", {tx_sof, rx_sof}, {2{mark(cnt, FRM)}});
            chk("somf", {tx_somf, rx_somf}, {2{mark(cnt, FRM*MFF)}});
            chk("emb_off", {tx_soemb, rx_soemb, tx_line_cmd_stb}, 3'h0);
            chk("rx_cmd_off", rx_cmd_tvalid, 1'b0);
        end
        cnt++;
    endtask : check_beat

    // link-side input is random traffic, changed at the falling edge
    always @(negedge mclk) begin
        for (int i = 0; i < DW / 32; i++) begin
            rx_line_data[i*32 +: 32] <= $random(seed);
        end
        rx_line_cmd <= 19'($random(seed));
    end

    always @(negedge mclk) begin
        #2;
        if (!chk_on) begin
            pend = 1'b0;
            q.delete();
        end else begin
            if (pend) check_beat();
            chk("running", {tx_tready, stream_rst_n}, 2'b11);
            chk("rdy", tx_cmd_tready, 1'(m64 && cnt % 32 == 31));
            pend = tx_tready;
            q.push_back(tx_tdata);
            prx = rx_line_data;
            prc = rx_line_cmd;
            pc = tx_cmd_tdata;
            pv = tx_cmd_tvalid;
        end
    end

    task automatic link_reset(input logic late);
        int k;
        @(negedge mclk);
        chk_on = 1'b0;
        core_reset = 1'b1;
        xcvr_reset_done = !late;
        repeat (6) @(negedge mclk);
        chk("req_in_reset", xcvr_reset_request, 1'b1);
        chk("srst_in_reset", {tx_tready, stream_rst_n}, 2'b00);
        core_reset = 1'b0;
        for (k = 1; k <= 40; k++) begin
            @(negedge mclk);
            if (k == 20) xcvr_reset_done = 1'b1;
            #1;
            if (k == 4) chk("req_held", xcvr_reset_request, 1'b1);
            if (k == 20) chk("srst_done_low", stream_rst_n, 1'b0);
            if (stream_rst_n === 1'b1) break;
        end
        chk("srst_rise", {k > 8, xcvr_reset_request}, 2'b10);
        m64 = cfg_mode64;
        cnt = 0;
        chk_on = 1'b1;
    endtask : link_reset

    initial begin
        #(MCLK_NS * 3000);
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (4) @(negedge mclk);
        // settings reset released on a falling clock edge
        rst_n = 1'b1;
        link_reset(1'b0);
        repeat (200) @(negedge mclk);
        // new mode must wait for the next link reset
        cfg_mode64 = 1'b0;
        repeat (64) @(negedge mclk);
        link_reset(1'b1);
        repeat (60) @(negedge mclk);
        stop_test();
    end
endmodule : test_converter_link_stream_port
